// >>> testbench/pll_loop_filter_enable_regs_tb_top.sv
/*
  Self-checking bench for the PLL register slice: AXI4-Lite read and write tasks
  and sequences of calls with expected values. Assumes the bound checker.
*/
`timescale 1ns/1ps
module pll_loop_filter_enable_regs_tb_top;
  import pll_regs_pkg::*;
  localparam logic [8:0] A_C1 = {IDX_CTRL_ONE, 2'h0};
  localparam logic [8:0] A_P1 = {IDX_CAP_ONE, 2'h0};
  localparam logic [8:0] A_P2 = {IDX_CAP_TWO, 2'h0};
  localparam logic [8:0] A_C2 = {IDX_CTRL_TWO, 2'h0};
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, main_en, refdiv_en, bias_en, out_en, active;
  logic [8:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [4:0]  cap_one, cap_two;
  int          err_count = 0;
  int          n_compared = 0;
  // Enable sequence: address, data, expected {main, bias, out, active}.
  logic [8:0]  en_a [6] = '{A_C2, A_C2, A_C1, A_C1, A_C1, A_C2};
  logic [7:0]  en_d [6] = '{8'hF9, 8'hFD, 8'h43, 8'h41, 8'hC3, 8'hF9};
  logic [3:0]  en_p [6] = '{4'h2, 4'h6, 4'hF, 4'h6, 4'hF, 4'hA};

  pll_loop_filter_enable_regs uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .loop_cap_one_sel(cap_one), .loop_cap_two_sel(cap_two), .pll_main_en(main_en),
    .pll_refdiv_en(refdiv_en), .pll_bias_en(bias_en), .pll_out_en(out_en), .pll_output_active(active));

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected data at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected response at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Address and data are offered together and each is dropped once taken.
  task automatic wr(input logic [8:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic aw_open, w_open, done;
    aw_open = 1'b1;
    w_open = 1'b1;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= s;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (aw_open && awready) begin aw_open = 1'b0; awvalid <= 1'b0; end
      if (w_open && wready) begin w_open = 1'b0; wvalid <= 1'b0; end
      if (bvalid) begin done = 1'b1; bready <= 1'b0; cmp_resp(bresp, er); end
    end
  endtask

  task automatic rd(input logic [8:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin done = 1'b1; rready <= 1'b0; cmp_data(rdata, ed); cmp_resp(rresp, er); end
    end
  endtask

  // Pins are looked at mid-cycle, after every update of the last edge has landed.
  task automatic chk_pins(input logic [4:0] c1, input logic [4:0] c2, input logic [3:0] en);
    @(negedge aclk);
    cmp_data({18'h0, cap_one, cap_two, main_en, bias_en, out_en, active}, {18'h0, c1, c2, en});
  endtask

  // Watchdog: the whole sequence needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge aclk);
    err_count++;
    $display("unexpected hang at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    results();
  end

  initial begin
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    awaddr = 9'h0; araddr = 9'h0; wdata = 32'h0; wstrb = 4'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(A_C1, 32'h41, RESP_OKAY);
    rd(A_P1, 32'h27, RESP_OKAY);
    rd(A_P2, 32'h27, RESP_OKAY);
    rd(A_C2, 32'hF1, RESP_OKAY);
    chk_pins(5'h07, 5'h07, 4'h0);
    $display("test reset_values done");
    // Factory bits 6:5 keep their default 01; bit 7 is set to prove it is dropped.
    wr(A_P1, 32'hFFFFFFBF, 4'hF, RESP_OKAY);
    wr(A_P2, 32'hFFFFFFBF, 4'hF, RESP_OKAY);
    chk_pins(5'h1F, 5'h1F, 4'h0);
    rd(A_P1, 32'h3F, RESP_OKAY);
    rd(A_P2, 32'h3F, RESP_OKAY);
    wr(A_P1, 32'hA0, 4'h1, RESP_OKAY);
    wr(A_P2, 32'hA0, 4'h1, RESP_OKAY);
    wr(A_P1, 32'h3F, 4'h0, RESP_OKAY);
    chk_pins(5'h00, 5'h00, 4'h0);
    rd(A_P1, 32'h20, RESP_OKAY);
    rd(A_P2, 32'h20, RESP_OKAY);
    $display("test cap_fields done");
    for (int i = 0; i < 6; i++) begin
      wr(en_a[i], {24'h0, en_d[i]}, 4'h1, RESP_OKAY);
      chk_pins(5'h00, 5'h00, en_p[i]);
    end
    rd(A_C1, 32'h43, RESP_OKAY);
    rd(A_C2, 32'hF9, RESP_OKAY);
    // Divider enable at bit 4 must reach its pin and read back; factory bits kept.
    wr(A_C1, 32'h53, 4'h1, RESP_OKAY);
    @(negedge aclk);
    cmp_data({31'h0, refdiv_en}, 32'h1);
    rd(A_C1, 32'h53, RESP_OKAY);
    $display("test enables done");
    wr(9'h160, 32'h1, 4'h1, RESP_SLVERR);
    rd(9'h160, 32'h0, RESP_SLVERR);
    rd(9'h178, 32'h0, RESP_SLVERR);
    $display("test unmapped done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(A_C2, 32'hF1, RESP_OKAY);
    rd(A_C1, 32'h41, RESP_OKAY);
    chk_pins(5'h07, 5'h07, 4'h0);
    cmp_data({31'h0, refdiv_en}, 32'h0);
    $display("test second_reset done");
    results();
  end
endmodule // pll_loop_filter_enable_regs_tb_top

// >>> testbench/pll_regs_checker.sv
/*
  Concurrent checks for the PLL loop-filter and enable register slice.
  Assumes it is bound to the slice's top module and sees only its ports.
*/
`timescale 1ns/1ps
module pll_regs_checker
  import pll_regs_pkg::*;
#(
  parameter int unsigned ADDR_W = 9
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_rvalid,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [4:0]        loop_cap_one_sel,
  input wire logic [4:0]        loop_cap_two_sel,
  input wire logic              pll_main_en,
  input wire logic              pll_bias_en,
  input wire logic              pll_out_en,
  input wire logic              pll_output_active
);
  import pll_regs_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Index of the read in flight, so read data can be tied to the pins it mirrors.
  logic [IDX_W-1:0] rd_idx;
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) rd_idx <= s_axi_araddr[ADDR_W-1:WORD_LSB];
  end

  a_out_active_and: assert property (pll_output_active == $past(pll_out_en && pll_bias_en && pll_main_en))
    else $error("output active does not follow the three enables");
  a_cap_one_read: assert property ($rose(s_axi_rvalid) && rd_idx == IDX_CAP_ONE
    |-> !s_axi_rdata[7] && s_axi_rdata[4:0] == loop_cap_one_sel)
    else $error("first capacitor read disagrees with its pins");
  a_cap_two_read: assert property ($rose(s_axi_rvalid) && rd_idx == IDX_CAP_TWO
    |-> !s_axi_rdata[7] && s_axi_rdata[4:0] == loop_cap_two_sel)
    else $error("second capacitor read disagrees with its pins");
  a_ctrl_two_read: assert property ($rose(s_axi_rvalid) && rd_idx == IDX_CTRL_TWO
    |-> s_axi_rdata[3:2] == {pll_out_en, pll_bias_en})
    else $error("enable register read disagrees with its pins");
  a_main_en_read: assert property ($rose(s_axi_rvalid) && rd_idx == IDX_CTRL_ONE
    |-> !s_axi_rdata[7] && s_axi_rdata[1] == pll_main_en)
    else $error("main enable read disagrees with its pin");
  a_reset_defaults: assert property ($rose(aresetn) |-> loop_cap_one_sel == 5'h07 && loop_cap_two_sel == 5'h07
    && !pll_main_en && !pll_bias_en && !pll_out_en && !pll_output_active)
    else $error("pins not at defaults after reset");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
    else $error("read answer late or upper bits set");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> !s_axi_bvalid ##2 s_axi_bvalid)
    else $error("write response not two cycles after the request");
endmodule // pll_regs_checker

bind pll_loop_filter_enable_regs pll_regs_checker #(.ADDR_W(ADDR_W)) chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata), .loop_cap_one_sel(loop_cap_one_sel),
  .loop_cap_two_sel(loop_cap_two_sel), .pll_main_en(pll_main_en), .pll_bias_en(pll_bias_en),
  .pll_out_en(pll_out_en), .pll_output_active(pll_output_active));

// >>> verilog/cfg_byte_reg.sv
/*
  One 8-bit configuration register with a per-bit implemented mask.
  Assumes a single-cycle write strobe from the bus logic on the same clock.
*/
`timescale 1ns/1ps
module cfg_byte_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] IMPL_MASK = 8'hFF
) (
  // Clock and reset.
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Write strobe and data.
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  // Stored value.
  output logic      [7:0] value
);

  typedef struct packed {
    logic [7:0] value;
  } state_s;

  state_s st_reg;
  state_s st_next;

  // Unimplemented bits are masked so they never store a one.
  always_comb begin
    st_next = st_reg;
    if (wr_en) begin
      st_next.value = wr_data & IMPL_MASK;
    end
  end

  // Power-on value for every implemented bit.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg.value <= RESET_VAL & IMPL_MASK;
    end else begin
      st_reg <= st_next;
    end
  end

  assign value = st_reg.value;

endmodule // cfg_byte_reg

// >>> verilog/pll_loop_filter_enable_regs.sv
/*
  PLL loop-filter capacitor and enable register slice behind an
  AXI4-Lite slave, with the derived PLL output-run level.
  Assumes one AXI master on the same clock issuing at most one write and
  one read at a time; only byte lane 0 carries register data.
*/
// Implementation choice: the AXI4-Lite interface to the registers.
// Notes on behaviour
// (R1) Bit 7 of both capacitor registers ignores writes and reads zero.
// (R2) First capacitor selector: read/write bits 4..0, resets to 00111.
// (R3) Second capacitor selector: read/write bits 4..0, resets to 00111.
// (R4) Software leaves factory fields at their reset values.
// (R5) Second enable register: output enable bit 3, bias enable bit 2, reset 0.
// (R6) PLL output runs only with output, bias and main enables all set.
// (R7) All implemented bits take their defaults at reset; factory 1111 and 01.
// (R8) Main PLL enable is read/write bit 1 of first enable register, reset 0.
// (R9) Reads return the last written value or the reset default.
`timescale 1ns/1ps
module pll_loop_filter_enable_regs
  import pll_regs_pkg::*;
#(
  parameter int unsigned ADDR_W = pll_regs_pkg::AXI_ADDR_W
) (
  // Clock and reset.
  input  wire logic                                aclk,
  input  wire logic                                aresetn,
  // Write address channel.
  input  wire logic                                s_axi_awvalid,
  output logic                                     s_axi_awready,
  input  wire logic [ADDR_W-1:0]                   s_axi_awaddr,
  input  wire logic [2:0]                          s_axi_awprot,
  // Write data channel.
  input  wire logic                                s_axi_wvalid,
  output logic                                     s_axi_wready,
  input  wire logic [pll_regs_pkg::AXI_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                          s_axi_wstrb,
  // Write response channel.
  output logic                                     s_axi_bvalid,
  input  wire logic                                s_axi_bready,
  output logic      [1:0]                          s_axi_bresp,
  // Read address channel.
  input  wire logic                                s_axi_arvalid,
  output logic                                     s_axi_arready,
  input  wire logic [ADDR_W-1:0]                   s_axi_araddr,
  input  wire logic [2:0]                          s_axi_arprot,
  // Read data channel.
  output logic                                     s_axi_rvalid,
  input  wire logic                                s_axi_rready,
  output logic      [pll_regs_pkg::AXI_DATA_W-1:0] s_axi_rdata,
  output logic      [1:0]                          s_axi_rresp,
  // Loop-filter settings to the analog PLL.
  output logic      [pll_regs_pkg::CAP_SEL_W-1:0]  loop_cap_one_sel,
  output logic      [pll_regs_pkg::CAP_SEL_W-1:0]  loop_cap_two_sel,
  // Enables to the analog PLL.
  output logic                                     pll_main_en,
  output logic                                     pll_refdiv_en,
  output logic                                     pll_bias_en,
  output logic                                     pll_out_en,
  output logic                                     pll_output_active
);

  import pll_regs_pkg::*;

  // Bus-side state; every bus output and the output-run level is one of these flops.
  typedef struct packed {
    wr_state_e               wr_state;
    rd_state_e               rd_state;
    logic                    awready;
    logic                    wready;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    arready;
    logic                    rvalid;
    logic [AXI_DATA_W-1:0]   rdata;
    logic [1:0]              rresp;
    logic                    aw_full;
    logic [ADDR_W-1:0]       aw_addr;
    logic                    w_full;
    logic [BYTE_W-1:0]       w_byte;
    logic                    w_lane;
    logic                    output_active;
  } state_s;

  state_s st_reg;
  state_s st_next;

  // Register contents and their write strobes.
  logic [BYTE_W-1:0]   ctrl_one_q;
  logic [BYTE_W-1:0]   cap_one_q;
  logic [BYTE_W-1:0]   cap_two_q;
  logic [BYTE_W-1:0]   ctrl_two_q;
  logic [NUM_REGS-1:0] reg_wr;
  logic                wr_fire;
  logic                wr_hit;
  logic                rd_hit;
  logic [BYTE_W-1:0]   rd_byte;
  logic [IDX_W-1:0]    wr_idx;
  logic [IDX_W-1:0]    rd_idx;

  // Word index of each access; the two low address bits are ignored.
  assign wr_idx = st_reg.aw_addr[WORD_LSB +: IDX_W];
  assign rd_idx = s_axi_araddr[WORD_LSB +: IDX_W];

  // A write commits once both address and data are held.
  assign wr_fire = (st_reg.wr_state == WR_COLLECT) && st_reg.aw_full && st_reg.w_full;

  // Write decode. A write with lane 0 off is answered but stores nothing.
  always_comb begin
    reg_wr = '0;
    wr_hit = 1'b1;
    if (wr_idx == IDX_CTRL_ONE) begin
      reg_wr[SEL_CTRL_ONE] = wr_fire && st_reg.w_lane; // R8
    end else if (wr_idx == IDX_CAP_ONE) begin
      reg_wr[SEL_CAP_ONE] = wr_fire && st_reg.w_lane; // R2
    end else if (wr_idx == IDX_CAP_TWO) begin
      reg_wr[SEL_CAP_TWO] = wr_fire && st_reg.w_lane; // R3
    end else if (wr_idx == IDX_CTRL_TWO) begin
      reg_wr[SEL_CTRL_TWO] = wr_fire && st_reg.w_lane; // R5
    end else begin
      wr_hit = 1'b0;
    end
  end

  // Read decode. Each register returns its stored byte in the low lane.
  always_comb begin
    rd_byte = '0;
    rd_hit  = 1'b1;
    if (rd_idx == IDX_CTRL_ONE) begin
      rd_byte = ctrl_one_q; // R9
    end else if (rd_idx == IDX_CAP_ONE) begin
      rd_byte = cap_one_q; // R1
    end else if (rd_idx == IDX_CAP_TWO) begin
      rd_byte = cap_two_q; // R1
    end else if (rd_idx == IDX_CTRL_TWO) begin
      rd_byte = ctrl_two_q; // R9
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Next-state logic for both bus directions and the output-run level.
  always_comb begin
    st_next = st_reg;

    // Address and data are caught independently, in either order.
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.aw_full = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.w_full = 1'b1;
      st_next.w_byte = s_axi_wdata[BYTE_W-1:0];
      st_next.w_lane = s_axi_wstrb[0];
    end

    // Write phase machine.
    case (st_reg.wr_state)
      WR_COLLECT: begin
        if (wr_fire) begin
          st_next.aw_full  = 1'b0;
          st_next.w_full   = 1'b0;
          st_next.bvalid   = 1'b1;
          st_next.bresp    = wr_hit ? RESP_OKAY : RESP_SLVERR;
          st_next.wr_state = WR_RESP;
        end
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          st_next.bvalid   = 1'b0;
          st_next.wr_state = WR_COLLECT;
        end
      end
      default: begin
        st_next.wr_state = WR_COLLECT;
      end
    endcase

    // Ready is registered, so it is computed from the coming state.
    st_next.awready = !st_next.aw_full && (st_next.wr_state == WR_COLLECT);
    st_next.wready  = !st_next.w_full && (st_next.wr_state == WR_COLLECT);

    // Read phase machine; the data word is latched at acceptance.
    case (st_reg.rd_state)
      RD_IDLE: begin
        if (s_axi_arvalid && st_reg.arready) begin
          st_next.rvalid   = 1'b1;
          st_next.rdata    = {{(AXI_DATA_W-BYTE_W){1'b0}}, rd_byte};
          st_next.rresp    = rd_hit ? RESP_OKAY : RESP_SLVERR;
          st_next.rd_state = RD_RESP;
        end
      end
      RD_RESP: begin
        if (s_axi_rready) begin
          st_next.rvalid   = 1'b0;
          st_next.rd_state = RD_IDLE;
        end
      end
      default: begin
        st_next.rd_state = RD_IDLE;
      end
    endcase
    st_next.arready = (st_next.rd_state == RD_IDLE);

    // The output runs one cycle after all three enables are set together and stops one cycle after any of them clears.
    st_next.output_active = ctrl_two_q[OUT_EN_BIT]
                          && ctrl_two_q[BIAS_EN_BIT]
                          && ctrl_one_q[MAIN_EN_BIT]; // R6
  end

  // State register. Ready outputs stay low through reset and rise after it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg.wr_state      <= WR_COLLECT;
      st_reg.rd_state      <= RD_IDLE;
      st_reg.awready       <= 1'b0;
      st_reg.wready        <= 1'b0;
      st_reg.bvalid        <= 1'b0;
      st_reg.bresp         <= RESP_OKAY;
      st_reg.arready       <= 1'b0;
      st_reg.rvalid        <= 1'b0;
      st_reg.rdata         <= '0;
      st_reg.rresp         <= RESP_OKAY;
      st_reg.aw_full       <= 1'b0;
      st_reg.aw_addr       <= '0;
      st_reg.w_full        <= 1'b0;
      st_reg.w_byte        <= '0;
      st_reg.w_lane        <= 1'b0;
      st_reg.output_active <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // First enable register: main enable, divider enable, factory bits.
  cfg_byte_reg #(
    .RESET_VAL (RST_CTRL_ONE),
    .IMPL_MASK (MASK_CTRL_ONE)
  ) u_ctrl_one (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (reg_wr[SEL_CTRL_ONE]),
    .wr_data (st_reg.w_byte),
    .value   (ctrl_one_q)
  ); // R8

  // First capacitor register; bit 7 is not built.
  cfg_byte_reg #(
    .RESET_VAL (RST_CAP),
    .IMPL_MASK (MASK_CAP)
  ) u_cap_one (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (reg_wr[SEL_CAP_ONE]),
    .wr_data (st_reg.w_byte),
    .value   (cap_one_q)
  ); // R1

  // Second capacitor register; bit 7 is not built.
  cfg_byte_reg #(
    .RESET_VAL (RST_CAP),
    .IMPL_MASK (MASK_CAP)
  ) u_cap_two (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (reg_wr[SEL_CAP_TWO]),
    .wr_data (st_reg.w_byte),
    .value   (cap_two_q)
  ); // R1

  // Second enable register; factory fields reset to ones above, 01 below.
  cfg_byte_reg #(
    .RESET_VAL (RST_CTRL_TWO),
    .IMPL_MASK (MASK_CTRL_TWO)
  ) u_ctrl_two (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (reg_wr[SEL_CTRL_TWO]),
    .wr_data (st_reg.w_byte),
    .value   (ctrl_two_q)
  ); // R7

  // Factory fields are stored as written; keeping them at default is
  // left to software, since blocking writes would hide a bad value.
  // R4

  // Bus outputs straight from the state flops.
  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready  = st_reg.wready;
  assign s_axi_bvalid  = st_reg.bvalid;
  assign s_axi_bresp   = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid  = st_reg.rvalid;
  assign s_axi_rdata   = st_reg.rdata;
  assign s_axi_rresp   = st_reg.rresp;

  // Analog controls come straight from the register flops; the output-run level comes from its state flop.
  assign loop_cap_one_sel  = cap_one_q[CAP_SEL_LSB +: CAP_SEL_W]; // R2
  assign loop_cap_two_sel  = cap_two_q[CAP_SEL_LSB +: CAP_SEL_W]; // R3
  assign pll_main_en       = ctrl_one_q[MAIN_EN_BIT]; // R8
  assign pll_refdiv_en     = ctrl_one_q[REFDIV_EN_BIT];
  assign pll_bias_en       = ctrl_two_q[BIAS_EN_BIT]; // R5
  assign pll_out_en        = ctrl_two_q[OUT_EN_BIT]; // R5
  assign pll_output_active = st_reg.output_active;

endmodule // pll_loop_filter_enable_regs

// >>> verilog/pll_regs_pkg.sv
/*
  Shared constants for the PLL loop-filter and enable register slice:
  register indices, reset values, implemented-bit masks, field positions,
  bus response codes and the bus-side state encodings.
  Assumes a 32-bit AXI4-Lite register bus with one register per aligned word.
*/
package pll_regs_pkg;

  // Bus geometry. Byte address is four times the register index.
  localparam int unsigned AXI_ADDR_W = 9;
  localparam int unsigned AXI_DATA_W = 32;
  localparam int unsigned WORD_LSB   = 2;
  localparam int unsigned IDX_W      = 7;
  localparam int unsigned BYTE_W     = 8;

  // Register indices as printed.
  localparam logic [6:0] IDX_CTRL_ONE = 7'h59;
  localparam logic [6:0] IDX_CAP_ONE  = 7'h5C;
  localparam logic [6:0] IDX_CAP_TWO  = 7'h5D;
  localparam logic [6:0] IDX_CTRL_TWO = 7'h5F;

  // Positions of the four registers in the write-enable vector.
  localparam int unsigned SEL_CTRL_ONE = 0;
  localparam int unsigned SEL_CAP_ONE  = 1;
  localparam int unsigned SEL_CAP_TWO  = 2;
  localparam int unsigned SEL_CTRL_TWO = 3;
  localparam int unsigned NUM_REGS     = 4;

  // Power-on values of whole registers.
  localparam logic [7:0] RST_CTRL_ONE = 8'h41;
  localparam logic [7:0] RST_CAP      = 8'h27;
  localparam logic [7:0] RST_CTRL_TWO = 8'hF1;

  // Implemented bits; bit 7 of the first three registers does not exist.
  localparam logic [7:0] MASK_CTRL_ONE = 8'h7F;
  localparam logic [7:0] MASK_CAP      = 8'h7F;
  localparam logic [7:0] MASK_CTRL_TWO = 8'hFF;

  // Field positions.
  localparam int unsigned CAP_SEL_LSB    = 0;
  localparam int unsigned CAP_SEL_W      = 5;
  localparam int unsigned MAIN_EN_BIT    = 1;
  localparam int unsigned REFDIV_EN_BIT  = 4;
  localparam int unsigned BIAS_EN_BIT    = 2;
  localparam int unsigned OUT_EN_BIT     = 3;

  // Bus response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Write and read channel phases.
  typedef enum logic [0:0] {
    WR_COLLECT = 1'b0,
    WR_RESP    = 1'b1
  } wr_state_e;

  typedef enum logic [0:0] {
    RD_IDLE = 1'b0,
    RD_RESP = 1'b1
  } rd_state_e;

endpackage
